// file: pkg/autocheck_defs.vh
`ifndef AUTOCHECK_DEFS_VH
`define AUTOCHECK_DEFS_VH

// register indices, byte address is index times four
`define IDX_ENTRY0      10'h10a
`define IDX_ENTRY1      10'h10b
`define IDX_ENTRY2      10'h12a
`define IDX_ENTRY3      10'h12b
`define IDX_GRANT0      10'h184
`define IDX_GRANT1      10'h185
`define IDX_GRANT2      10'h186
`define IDX_GRANT3      10'h187
`define IDX_SETUP       10'h1c5
`define IDX_FAULT_STATE 10'h1d2
`define IDX_IRQ_STATE   10'h1d4
`define IDX_MON_STATE   10'h1e0
`define IDX_RET_MODE    10'h1e1

// predriver_setup fields
`define SETUP_RET_EN    0
`define SETUP_DRV_EN    1

// irq_state_word fields
`define IRQ_ACTIVE_BIT  15
`define IRQ_SRC_LSB     10
`define IRQ_ADDR_W      10

// opcodes, fixed upper bits; the alias definition also has fixed low bits
`define OP_MON_ONE      11'b00110100110
`define OP_MON_ALL      15'b001101100000000
`define OP_MON_ALIAS    8'b00100110
`define OP_RET_CONF     14'b00110110000001
`define OP_RET          14'b00110101100110
`define OP_ALIAS_DEF_HI 2'b10
`define OP_ALIAS_DEF_LO 2'b11

// alias-monitor field codes
`define FLD_KEEP        2'b00
`define FLD_OFF         2'b10
`define FLD_ON          2'b11

// return-request handling modes
`define MODE_NONE       2'b00
`define MODE_CONTINUE   2'b10
`define MODE_RESTART    2'b11

// driver codes of the alias definition
`define CODE_LAST_HIGH  4'h4
`define CODE_FIRST_LOW  4'h5
`define CODE_LAST_MON   4'ha
`define CODE_UNDEF      4'hc

`define MON_COUNT       16
`define RESET_ZERO16    16'h0000

`endif

// file: verilog/autocheck_irq_core.v
// Notes on behaviour
// - single-output instruction turns one monitor off with 0, on with 1
// - selector: high-side 1-5 vds/src pairs 0000-1001, low-side 1-6 at 1010-1111
// - single-output opcode fixed bits 15:5, selector 4:1, enable bit 0
// - monitor changes apply only to outputs granted to this core
// - all monitors off after reset
// - all-outputs instruction applies bit 0 to every granted output; faults interrupt
// - alias instruction drives four monitors in parallel
// - alias field: 00 keep, 01 ignored, 10 off, 11 on
// - alias fields at 7:6, 5:4, 3:2, 1:0 under fixed opcode byte
// - return config: none ignores requests, 10 continue, 11 restart
// - return config opcode fixed upper bits, setting in bits 1:0
// - return handling is none after reset
// - with return-enable set, re-enabling drivers issues a return request
// - with return-enable clear, fault status access issues the return request; it clears on read
// - return instruction ends the routine and clears the interrupt state word
// - type 0 resumes at saved address, type 1 at entry point
// - clear bit 1 flushes pending queue, 0 keeps it
// - return opcode fixed upper bits, type bit 1, clear bit 0
// - alias outputs follow the alias definition; code 1100 is undefined
`timescale 1ns/1ns
`default_nettype none
`include "autocheck_defs.vh"

module autocheck_irq_core #(
  parameter       ENTRY_SEL  = 0,
  parameter       GRANT_SEL  = 0,
  parameter [3:0] ALIAS1_RST = 4'h0,
  parameter [3:0] ALIAS2_RST = 4'h5,
  parameter [3:0] ALIAS3_RST = 4'h9
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        instr_valid,
  input  wire [15:0] instr_word,
  input  wire [9:0]  program_counter,
  input  wire [15:0] fault_feedback,
  output reg  [15:0] monitor_en_q,
  output reg         irq_active_q,
  output reg         pc_load_q,
  output reg  [9:0]  pc_target_q
);

  // ************************************************************
  // registers
  // ************************************************************
  reg  [15:0] entry_q [0:3];
  reg  [15:0] grant_q [0:3];
  reg  [15:0] setup_q;
  reg  [15:0] fault_state_q;
  reg  [15:0] irq_state_q;
  reg  [1:0]  ret_mode_q;
  reg  [15:0] pending_q;
  reg  [15:0] hit_prev_q;
  reg  [15:0] sync1_q;
  reg  [15:0] sync2_q;
  reg  [15:0] sync3_q;
  reg  [15:0] fb_q;
  reg  [3:0]  alias1_q;
  reg  [3:0]  alias2_q;
  reg  [3:0]  alias3_q;

  reg  [31:0] rd_d;
  reg         err_d;
  reg  [15:0] set_m;
  reg  [15:0] clr_m;
  reg  [15:0] grant_m;
  reg  [4:0]  pick;
  integer     i, j, k;

  wire [9:0]  idx       = paddr[11:2];
  wire        done      = psel & penable & pready;
  wire        wr_done   = done & pwrite;
  wire [15:0] wdata     = pwdata[15:0];
  wire [9:0]  entry_pc  = entry_q[ENTRY_SEL][9:0];
  wire [15:0] grant_reg = grant_q[GRANT_SEL];

  // ************************************************************
  // monitor index lookups
  // ************************************************************
  // returns {valid, index}; ls7 and undefined codes have no vds monitor
  function [4:0] vds_idx;
    input [3:0] code;
    begin
      if (code <= `CODE_LAST_HIGH)
        vds_idx = {1'b1, code[2:0], 1'b0};
      else if (code <= `CODE_LAST_MON)
        vds_idx = {1'b1, code + 4'h5};
      else
        vds_idx = 5'h00;
    end
  endfunction

  // only high-side drivers carry a source monitor
  function [4:0] src_idx;
    input [3:0] code;
    begin
      if (code <= `CODE_LAST_HIGH)
        src_idx = {1'b1, code[2:0], 1'b1};
      else
        src_idx = 5'h00;
    end
  endfunction

  // ************************************************************
  // instruction decode
  // ************************************************************
  wire is_one   = instr_valid & (instr_word[15:5] == `OP_MON_ONE);
  wire is_all   = instr_valid & (instr_word[15:1] == `OP_MON_ALL);
  wire is_alias = instr_valid & (instr_word[15:8] == `OP_MON_ALIAS);
  wire is_conf  = instr_valid & (instr_word[15:2] == `OP_RET_CONF);
  wire is_ret   = instr_valid & (instr_word[15:2] == `OP_RET);
  wire is_def   = instr_valid & (instr_word[15:14] == `OP_ALIAS_DEF_HI)
                  & (instr_word[1:0] == `OP_ALIAS_DEF_LO);
  wire ret_type = instr_word[1];
  wire ret_rst  = instr_word[0];

  wire [4:0] a1v = vds_idx(alias1_q);
  wire [4:0] a1s = src_idx(alias1_q);
  wire [4:0] a2v = vds_idx(alias2_q);
  wire [4:0] a3v = vds_idx(alias3_q);

  // ************************************************************
  // grant mask per monitor
  // ************************************************************
  // grant bits 4:0 high-side 1-5, bits 11:5 low-side 1-7
  always @*
  begin
    grant_m = `RESET_ZERO16;
    for (i = 0; i < 10; i = i + 1)
      grant_m[i] = grant_reg[i/2];
    for (i = 10; i < 16; i = i + 1)
      grant_m[i] = grant_reg[i-5];
  end

  // ************************************************************
  // monitor set and clear masks
  // ************************************************************
  always @*
  begin
    set_m = `RESET_ZERO16;
    clr_m = `RESET_ZERO16;
    if (is_one)
    begin
      if (instr_word[0])
        set_m[instr_word[4:1]] = 1'b1;
      else
        clr_m[instr_word[4:1]] = 1'b1;
    end
    if (is_all)
    begin
      if (instr_word[0])
        set_m = 16'hffff;
      else
        clr_m = 16'hffff;
    end
    if (is_alias)
    begin
      if (a1v[4] && instr_word[7:6] == `FLD_ON)
        set_m[a1v[3:0]] = 1'b1;
      if (a1v[4] && instr_word[7:6] == `FLD_OFF)
        clr_m[a1v[3:0]] = 1'b1;
      if (a1s[4] && instr_word[5:4] == `FLD_ON)
        set_m[a1s[3:0]] = 1'b1;
      if (a1s[4] && instr_word[5:4] == `FLD_OFF)
        clr_m[a1s[3:0]] = 1'b1;
      if (a2v[4] && instr_word[3:2] == `FLD_ON)
        set_m[a2v[3:0]] = 1'b1;
      if (a2v[4] && instr_word[3:2] == `FLD_OFF)
        clr_m[a2v[3:0]] = 1'b1;
      if (a3v[4] && instr_word[1:0] == `FLD_ON)
        set_m[a3v[3:0]] = 1'b1;
      if (a3v[4] && instr_word[1:0] == `FLD_OFF)
        clr_m[a3v[3:0]] = 1'b1;
    end
    set_m = set_m & grant_m;
    clr_m = clr_m & grant_m;
  end

  // ************************************************************
  // fault detection
  // ************************************************************
  // sync1 feeds only sync2; a change counts once sync2 and sync3 agree
  wire [15:0] fb_d   = (sync2_q & sync3_q) | (fb_q & (sync2_q | sync3_q));
  wire [15:0] hit    = fb_q & monitor_en_q;
  wire [15:0] hit_up = hit & ~hit_prev_q;

  // lowest pending source wins
  always @*
  begin
    pick = 5'h00;
    for (j = `MON_COUNT - 1; j >= 0; j = j - 1)
      if (pending_q[j])
        pick = {1'b1, j[3:0]};
  end

  // ************************************************************
  // return requests
  // ************************************************************
  wire drv_up    = wr_done & (idx == `IDX_SETUP) & wdata[`SETUP_DRV_EN]
                   & ~setup_q[`SETUP_DRV_EN];
  wire stat_acc  = done & (idx == `IDX_FAULT_STATE);
  wire auto_req  = setup_q[`SETUP_RET_EN] ? drv_up : stat_acc;
  // modes none and not-applicable both ignore the request
  wire auto_take = auto_req & irq_active_q & ret_mode_q[1];
  wire ret_take  = is_ret & irq_active_q;
  wire leave     = ret_take | auto_take;
  wire to_entry  = ret_take ? ret_type : (ret_mode_q == `MODE_RESTART);
  wire enter     = ~irq_active_q & pick[4] & ~pc_load_q;

  // ************************************************************
  // apb read mux
  // ************************************************************
  always @*
  begin
    rd_d  = 32'h00000000;
    err_d = 1'b0;
    case (idx)
      `IDX_ENTRY0:      rd_d[15:0] = entry_q[0];
      `IDX_ENTRY1:      rd_d[15:0] = entry_q[1];
      `IDX_ENTRY2:      rd_d[15:0] = entry_q[2];
      `IDX_ENTRY3:      rd_d[15:0] = entry_q[3];
      `IDX_GRANT0:      rd_d[15:0] = grant_q[0];
      `IDX_GRANT1:      rd_d[15:0] = grant_q[1];
      `IDX_GRANT2:      rd_d[15:0] = grant_q[2];
      `IDX_GRANT3:      rd_d[15:0] = grant_q[3];
      `IDX_SETUP:       rd_d[15:0] = setup_q;
      `IDX_FAULT_STATE: rd_d[15:0] = fault_state_q;
      `IDX_IRQ_STATE:   rd_d[15:0] = irq_state_q;
      `IDX_MON_STATE:   rd_d[15:0] = monitor_en_q;
      `IDX_RET_MODE:    rd_d[1:0]  = ret_mode_q;
      default:          err_d      = 1'b1;
    endcase
  end

  // ************************************************************
  // apb slave handshake
  // ************************************************************
  // one wait-free access phase; data captured in setup, stable after
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable & ~pready;
      if (psel & ~penable)
      begin
        prdata  <= pwrite ? 32'h00000000 : rd_d;
        pslverr <= err_d;
      end
    end
  end

  // ************************************************************
  // software registers
  // ************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (k = 0; k < 4; k = k + 1)
      begin
        entry_q[k] <= `RESET_ZERO16;
        grant_q[k] <= `RESET_ZERO16;
      end
      setup_q       <= `RESET_ZERO16;
      fault_state_q <= `RESET_ZERO16;
    end
    else
    begin
      if (wr_done)
      begin
        case (idx)
          `IDX_ENTRY0: entry_q[0] <= wdata;
          `IDX_ENTRY1: entry_q[1] <= wdata;
          `IDX_ENTRY2: entry_q[2] <= wdata;
          `IDX_ENTRY3: entry_q[3] <= wdata;
          `IDX_GRANT0: grant_q[0] <= wdata;
          `IDX_GRANT1: grant_q[1] <= wdata;
          `IDX_GRANT2: grant_q[2] <= wdata;
          `IDX_GRANT3: grant_q[3] <= wdata;
          `IDX_SETUP:  setup_q    <= wdata;
          default:     setup_q    <= setup_q;
        endcase
      end
      // clears only what the read reported; later faults survive
      if (stat_acc & ~pwrite)
        fault_state_q <= (fault_state_q & ~prdata[15:0]) | hit_up;
      else
        fault_state_q <= fault_state_q | hit_up;
    end
  end

  // ************************************************************
  // feedback synchroniser
  // ************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_q    <= `RESET_ZERO16;
      sync2_q    <= `RESET_ZERO16;
      sync3_q    <= `RESET_ZERO16;
      fb_q       <= `RESET_ZERO16;
      hit_prev_q <= `RESET_ZERO16;
    end
    else
    begin
      sync1_q    <= fault_feedback;
      sync2_q    <= sync1_q;
      sync3_q    <= sync2_q;
      fb_q       <= fb_d;
      hit_prev_q <= hit;
    end
  end

  // ************************************************************
  // monitor enables and alias map
  // ************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      monitor_en_q <= `RESET_ZERO16;
      alias1_q     <= ALIAS1_RST;
      alias2_q     <= ALIAS2_RST;
      alias3_q     <= ALIAS3_RST;
      ret_mode_q   <= `MODE_NONE;
    end
    else
    begin
      monitor_en_q <= (monitor_en_q & ~clr_m) | set_m;
      if (is_def)
      begin
        alias1_q <= instr_word[13:10];
        alias2_q <= instr_word[9:6];
        alias3_q <= instr_word[5:2];
      end
      if (is_conf)
        ret_mode_q <= instr_word[1:0];
    end
  end

  // ************************************************************
  // interrupt service and pending queue
  // ************************************************************
  // entry waits out the jump pulse so the saved address is the resumed one
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pending_q    <= `RESET_ZERO16;
      irq_active_q <= 1'b0;
      irq_state_q  <= `RESET_ZERO16;
      pc_load_q    <= 1'b0;
      pc_target_q  <= 10'h000;
    end
    else
    begin
      pc_load_q <= leave;
      if (leave)
      begin
        irq_active_q <= 1'b0;
        irq_state_q  <= `RESET_ZERO16;
        pc_target_q  <= to_entry ? entry_pc : irq_state_q[9:0];
        // flush loses to a fault arriving in the same cycle
        if (ret_take & ret_rst)
          pending_q <= hit_up;
        else
          pending_q <= pending_q | hit_up;
      end
      else if (enter)
      begin
        irq_active_q <= 1'b1;
        irq_state_q  <= {1'b1, 1'b0, pick[3:0], program_counter};
        pending_q    <= (pending_q & ~(16'h0001 << pick[3:0])) | hit_up;
      end
      else
        pending_q <= pending_q | hit_up;
    end
  end

endmodule

`default_nettype wire

// file: tb/autocheck_chk.sv
`timescale 1ns/1ns
`default_nettype none
`include "autocheck_defs.vh"
// ****************************************
// monitor and return checks
// ****************************************
module autocheck_chk (
  input wire        pclk,
  input wire        presetn,
  input wire        instr_valid,
  input wire [15:0] instr_word,
  input wire [15:0] fault_feedback,
  input wire [15:0] monitor_en_q,
  input wire        irq_active_q,
  input wire        pc_load_q
);
  wire hit;
  wire op_one;
  wire op_all;
  wire op_als;
  wire op_ret;
  assign hit = |(fault_feedback & monitor_en_q);
  assign op_one = instr_valid && instr_word[15:5] == `OP_MON_ONE;
  assign op_all = instr_valid && instr_word[15:1] == `OP_MON_ALL;
  assign op_als = instr_valid && instr_word[15:8] == `OP_MON_ALIAS;
  assign op_ret = instr_valid && instr_word[15:2] == `OP_RET;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  one_sel_a: assert property (
    op_one |=> ((monitor_en_q ^ $past(monitor_en_q)) & ~(16'h1 << $past(instr_word[4:1]))) == 16'h0)
    else $error("single enable touched another monitor");
  one_dir_a: assert property (
    op_one |=> monitor_en_q[$past(instr_word[4:1])] == $past(instr_word[0]) || $stable(monitor_en_q))
    else $error("single enable wrote the wrong level");
  all_dir_a: assert property (
    op_all |=> ($past(instr_word[0]) ? (~monitor_en_q & $past(monitor_en_q))
                                     : (monitor_en_q & ~$past(monitor_en_q))) == 16'h0)
    else $error("all-outputs enable moved bits the wrong way");
  alias_keep_a: assert property (
    op_als && (instr_word[7:0] == 8'h00 || instr_word[7:0] == 8'h55) |=> $stable(monitor_en_q))
    else $error("keep or ignored alias field changed a monitor");
  alias_on_a: assert property (
    op_als && instr_word[7:0] == 8'hff |=> (~monitor_en_q & $past(monitor_en_q)) == 16'h0)
    else $error("alias enable cleared a monitor");
  mon_idle_a: assert property (
    !instr_valid |=> $stable(monitor_en_q))
    else $error("monitors changed without an instruction");
  ret_end_a: assert property (
    op_ret && irq_active_q |=> !irq_active_q && pc_load_q)
    else $error("return did not end the routine");
  ret_idle_a: assert property (
    op_ret && !irq_active_q |=> !pc_load_q)
    else $error("return outside service jumped");
  load_pulse_a: assert property (
    pc_load_q |-> !irq_active_q && $past(irq_active_q))
    else $error("jump without leaving service");
  fault_irq_a: assert property (
    $rose(hit) && !irq_active_q |-> ##[1:12] irq_active_q)
    else $error("fault on enabled monitor raised no interrupt");
endmodule

bind autocheck_irq_core autocheck_chk i_chk (
  .pclk           (pclk),
  .presetn        (presetn),
  .instr_valid    (instr_valid),
  .instr_word     (instr_word),
  .fault_feedback (fault_feedback),
  .monitor_en_q   (monitor_en_q),
  .irq_active_q   (irq_active_q),
  .pc_load_q      (pc_load_q)
);
`default_nettype wire

// file: tb/seq_fb_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// sequencer and feedback comparators
// ****************************************
module seq_fb_model #(
  parameter [9:0] START_PC = 10'h155
) (
  input  wire            pclk,
  input  wire            presetn,
  input  wire     [15:0] fault_req,
  input  wire            pc_load_q,
  input  wire     [9:0]  pc_target_q,
  output var logic [9:0] program_counter,
  output logic    [15:0] fault_feedback
);
  // parked on a wait, so the counter only moves on a jump
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      program_counter <= START_PC;
    else if (pc_load_q)
      program_counter <= pc_target_q;
  assign fault_feedback = fault_req;
endmodule
`default_nettype wire

// file: tb/tb_autocheck_irq_core.sv
`timescale 1ns/1ns
`default_nettype none
`include "autocheck_defs.vh"
module tb_autocheck_irq_core;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, instr_valid = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  logic [15:0] instr_word = 0, fault_req = 0, exp, grant;
  logic [9:0]  tgt;
  wire  [31:0] prdata;
  wire         pready, pslverr, irq_active_q, pc_load_q;
  wire  [15:0] monitor_en_q, fault_feedback;
  wire  [9:0]  program_counter, pc_target_q;
  int          errors = 0, checked = 0, loads = 0, cyc = 0, i, n, l0;

  autocheck_irq_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .instr_valid(instr_valid), .instr_word(instr_word),
    .program_counter(program_counter), .fault_feedback(fault_feedback),
    .monitor_en_q(monitor_en_q), .irq_active_q(irq_active_q), .pc_load_q(pc_load_q),
    .pc_target_q(pc_target_q));
  seq_fb_model i_model (.pclk(pclk), .presetn(presetn), .fault_req(fault_req),
    .pc_load_q(pc_load_q), .pc_target_q(pc_target_q), .program_counter(program_counter),
    .fault_feedback(fault_feedback));

  always #5 pclk = ~pclk;
  always @(posedge pclk)
    if (pc_load_q === 1'b1)
    begin
      loads <= loads + 1;
      tgt <= pc_target_q;
    end
  // ****************************************
  // shared tasks
  // ****************************************
  task test_done;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      errors++;
      $display("Error timeout expected done seen hang");
      test_done;
    end
  end
  task chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task apb(input logic w, input logic [9:0] idx, input logic [15:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdc(input string what, input logic [9:0] idx, input logic [15:0] e);
    apb(1'b0, idx, 16'h0000);
    chk(what, {16'h0000, e}, rd);
  endtask
  task ins(input logic [15:0] w);
    @(posedge pclk);
    instr_valid <= 1'b1;
    instr_word <= w;
    @(posedge pclk);
    instr_valid <= 1'b0;
    @(posedge pclk);
  endtask
  task mon(input logic [15:0] e);
    chk("monitor_en_q", {16'h0000, e}, {16'h0000, monitor_en_q});
  endtask
  task wirq(input logic v);
    n = 0;
    while (irq_active_q !== v && n < 30)
    begin
      @(posedge pclk);
      n++;
    end
    chk("irq_active_q", {31'h0, v}, {31'h0, irq_active_q});
  endtask
  task wload(input logic [9:0] e);
    n = 0;
    while (loads == l0 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    chk("pc_loads", l0 + 1, loads);
    chk("pc_target_q", {22'h0, e}, {22'h0, tgt});
  endtask
  task fault(input logic [15:0] f);
    fault_req <= 16'h0000;
    repeat (8) @(posedge pclk);
    fault_req <= f;
    wirq(1'b1);
  endtask
  function logic [15:0] w_one(input logic [3:0] s, input logic d);
    return {`OP_MON_ONE, s, d};
  endfunction
  function logic [15:0] w_all(input logic d);
    return {`OP_MON_ALL, d};
  endfunction
  function logic [15:0] w_ret(input logic t, input logic r);
    return {`OP_RET, t, r};
  endfunction
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    mon(16'h0000);
    rdc("ret_mode", `IDX_RET_MODE, 16'h0000);
    apb(1'b0, 10'h000, 16'h0000);
    chk("pslverr", 32'h1, {31'h0, err});
    grant = 16'h0035;
    apb(1'b1, `IDX_GRANT0, grant);
    exp = 16'h0000;
    for (i = 0; i < 16; i++)
    begin
      ins(w_one(i[3:0], 1'b1));
      // granted hs1, hs3, hs5, ls1: monitors 0,1,4,5,8,9,10
      exp = 16'h0733 & ~(16'hfffe << i);
      mon(exp);
    end
    ins(w_one(4'h4, 1'b0));
    mon(16'h0723);
    $display("single enable test done");
    apb(1'b1, `IDX_GRANT0, 16'h0fff);
    ins(w_all(1'b1));
    mon(16'hffff);
    ins(w_all(1'b0));
    mon(16'h0000);
    ins({`OP_MON_ALIAS, 8'hff});
    mon(16'h4403);
    ins({`OP_MON_ALIAS, 8'h24});
    mon(16'h4401);
    ins({`OP_MON_ALIAS, 8'h55});
    mon(16'h4401);
    ins(w_all(1'b0));
    ins({`OP_ALIAS_DEF_HI, 4'h1, 4'ha, `CODE_UNDEF, `OP_ALIAS_DEF_LO});
    ins({`OP_MON_ALIAS, 8'hff});
    mon(16'h800c);
    ins(w_all(1'b0));
    $display("alias test done");
    ins(w_one(4'h0, 1'b1));
    fault(16'h0001);
    rdc("irq_state", `IDX_IRQ_STATE, 16'h8155);
    rdc("fault_state", `IDX_FAULT_STATE, 16'h0001);
    rdc("fault_state", `IDX_FAULT_STATE, 16'h0000);
    chk("irq_active_q", 32'h1, {31'h0, irq_active_q});
    l0 = loads;
    ins(w_ret(1'b0, 1'b0));
    wload(10'h155);
    rdc("irq_state", `IDX_IRQ_STATE, 16'h0000);
    ins({`OP_RET_CONF, `MODE_CONTINUE});
    rdc("ret_mode", `IDX_RET_MODE, 16'h0002);
    fault(16'h0001);
    l0 = loads;
    rdc("fault_state", `IDX_FAULT_STATE, 16'h0001);
    wload(10'h155);
    $display("continue test done");
    apb(1'b1, `IDX_ENTRY0, 16'h0234);
    ins({`OP_RET_CONF, `MODE_RESTART});
    apb(1'b1, `IDX_SETUP, 16'h0001);
    fault(16'h0001);
    l0 = loads;
    rdc("fault_state", `IDX_FAULT_STATE, 16'h0001);
    repeat (4) @(posedge pclk);
    chk("irq_active_q", 32'h1, {31'h0, irq_active_q});
    apb(1'b1, `IDX_SETUP, 16'h0003);
    wload(10'h234);
    $display("restart test done");
    apb(1'b1, `IDX_SETUP, 16'h0000);
    apb(1'b1, `IDX_ENTRY0, 16'h0077);
    ins(w_all(1'b1));
    fault(16'h0007);
    rdc("irq_state", `IDX_IRQ_STATE, 16'h8234);
    l0 = loads;
    ins(w_ret(1'b1, 1'b0));
    wload(10'h077);
    wirq(1'b1);
    rdc("irq_state", `IDX_IRQ_STATE, 16'h8477);
    l0 = loads;
    ins(w_ret(1'b0, 1'b1));
    wload(10'h077);
    repeat (10) @(posedge pclk);
    chk("irq_active_q", 32'h0, {31'h0, irq_active_q});
    l0 = loads;
    ins(w_ret(1'b0, 1'b0));
    repeat (3) @(posedge pclk);
    chk("pc_loads", l0, loads);
    $display("queue test done");
    test_done;
  end
endmodule
`default_nettype wire
